// >>> core/edcr_consts.svh
`ifndef EDCR_CONSTS_SVH
`define EDCR_CONSTS_SVH

// Slot register offsets
`define EDCR_OFF_ID_LO 10'h000
`define EDCR_OFF_ID_HI 10'h002
`define EDCR_OFF_CAT 10'h00a
`define EDCR_OFF_PROD 10'h00c
`define EDCR_OFF_COMP 10'h00e
`define EDCR_OFF_BASE_A 10'h010
`define EDCR_OFF_BASE_B 10'h012
`define EDCR_OFF_DMA 10'h014
`define EDCR_OFF_EN 10'h016
`define EDCR_OFF_MSK_LO 10'h018
`define EDCR_OFF_MSK_HI 10'h01a
`define EDCR_OFF_STS_LO 10'h01c
`define EDCR_OFF_STS_HI 10'h01e
`define EDCR_OFF_DEV_AREA 10'h020
// Field positions and values
`define EDCR_EN_BIT 0
`define EDCR_MASK_MODE_BIT 1
`define EDCR_CAT_BRIDGE_BIT 15
`define EDCR_BASE_BITS 16'h1fff
`define EDCR_DMA_BITS 16'h000e
`define EDCR_EN_BITS 16'h0003
`define EDCR_EN_DISCOVER 16'h0002
`define EDCR_EN_NORMAL 16'h0000
`define EDCR_RST_REG 16'h0000
`define EDCR_LAST_SLOT 4'hf
// Host no-answer timeout
`define EDCR_TOUT_NS 1000
`define EDCR_CLK_MHZ 200
`define EDCR_TOUT_CYC ((`EDCR_TOUT_NS * `EDCR_CLK_MHZ) / 1000)
`define EDCR_TOUT_W 8
// Host APB register offsets
`define EDCR_APB_CTRL 8'h00
`define EDCR_APB_ADDR 8'h04
`define EDCR_APB_WDATA 8'h08
`define EDCR_APB_STATUS 8'h0c
`define EDCR_APB_REQMAP 8'h14
`define EDCR_APB_RES 8'h20
`endif

// >>> core/edcr_pkg.sv
package edcr_pkg;
  // Device access sequencer states
  typedef enum logic [2:0] {
    d_idle = 3'b001,
    d_acc = 3'b010,
    d_done = 3'b100
  } edcr_dst_e;
  // Host sequencer states
  typedef enum logic [2:0] {
    h_idle = 3'b001,
    h_load = 3'b010,
    h_issue = 3'b100
  } edcr_hst_e;
  // Host commands
  typedef enum logic [2:0] {
    cmd_none = 3'h0,
    cmd_access = 3'h1,
    cmd_scan = 3'h2,
    cmd_discover = 3'h3,
    cmd_enable = 3'h4
  } edcr_cmd_e;
  // One bus step of a host command
  typedef struct packed {
    logic last;
    logic we;
    logic [9:0] off;
    logic [15:0] wd;
  } edcr_step_s;
endpackage

// >>> core/edcr_if.sv
interface edcr_if;
  // Access request from host
  logic req;
  logic we;
  logic ext;
  logic [28:0] addr;
  logic [15:0] wdata;
  // Answer from device
  logic ack;
  logic [15:0] rdata;
  // Open-drain interrupt and DMA request lines
  logic irq_o;
  logic irq_oe;
  logic irq_n;
  logic [2:0] rq_o;
  logic [2:0] rq_oe;
  logic [2:0] rq_n;

  // Pull-up resolution of the open-drain lines
  assign irq_n = irq_oe ? irq_o : 1'b1;
  assign rq_n = (rq_o & rq_oe) | ~rq_oe;

  modport dev (
    input req, we, ext, addr, wdata,
    output ack, rdata, irq_o, irq_oe, rq_o, rq_oe
  );
  modport host (
    output req, we, ext, addr, wdata,
    input ack, rdata, irq_n, rq_n
  );
endinterface

// >>> core/edcr_dev.sv
`include "edcr_consts.svh"

module edcr_dev
  import edcr_pkg::*;
#(
  // Identifier words, values arbitrary
  parameter logic [15:0] ID_LO = 16'h5a01,
  parameter logic [15:0] ID_HI = 16'h5a02,
  parameter logic [15:0] CATEGORY = 16'h0000,
  parameter logic [15:0] PRODUCT = 16'h0000,
  parameter logic [15:0] COMPAT = 16'h0000,
  // Settable bits of each resource register
  parameter logic [15:0] WM_BASE_A = 16'h1ff0,
  parameter logic [15:0] WM_BASE_B = 16'h1fff,
  parameter logic [15:0] WM_DMA = 16'h000e,
  parameter logic [31:0] WM_IRQ = 32'hffff_ffff
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Expansion bus
  edcr_if.dev bus,
  // Slot select straps
  input wire logic [3:0] slot,
  // Interrupt sources and DMA requests
  input wire logic [31:0] irq_src,
  input wire logic [2:0] dma_req,
  // Device-specific access port
  output logic dev_en,
  output logic dev_req,
  output logic dev_we,
  output logic [1:0] dev_region,
  output logic [28:0] dev_addr,
  output logic [15:0] dev_wdata,
  input wire logic [15:0] dev_rdata
);

  // ****************************************
  // Declarations
  // ****************************************
  edcr_dst_e st_q;
  logic [3:0] slot_s1_q;
  logic [3:0] slot_s2_q;
  logic [15:0] base_a_q;
  logic [15:0] base_b_q;
  logic [15:0] dma_q;
  logic [15:0] en_q;
  logic [31:0] msk_q;
  logic [31:0] sts_q;
  logic [1:0] rgn_q;
  logic we_q;
  logic [28:0] adr_q;
  logic [15:0] wd_q;
  logic [15:0] rd_q;
  logic hit_s;
  logic hit_a;
  logic hit_b;
  logic take;
  logic [9:0] offe;
  logic cfg_acc;
  logic cfg_wr;
  logic mmode;
  logic [31:0] clr;
  logic [15:0] rd_cfg;

  // Window match on address bits 28:16
  function automatic logic win_hit(logic [15:0] base, logic [15:0] wm,
                                   logic [28:0] a);
    logic [12:0] diff;
    diff = (a[28:16] ^ base[12:0]) & wm[12:0];
    win_hit = (base != 16'h0000) && (diff == 13'h0000);
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  // Straps pass two flops
  always_ff @(posedge mclk) begin
    slot_s1_q <= slot;
    slot_s2_q <= slot_s1_q;
  end

  // Slot hit ignores enable; windows need it
  assign hit_s = !bus.ext && (bus.addr[28:14] == 15'h0000)
                 && (bus.addr[13:10] == slot_s2_q);
  assign hit_a = bus.ext && en_q[`EDCR_EN_BIT]
                 && win_hit(base_a_q, WM_BASE_A, bus.addr);
  assign hit_b = bus.ext && en_q[`EDCR_EN_BIT]
                 && win_hit(base_b_q, WM_BASE_B, bus.addr);
  assign take = bus.req && (st_q == d_idle) && (hit_s || hit_a || hit_b);

  // Halfword offset inside the slot
  assign offe = {adr_q[9:1], 1'b0};
  assign cfg_acc = (rgn_q == 2'd0) && (offe < `EDCR_OFF_DEV_AREA);
  assign cfg_wr = (st_q == d_acc) && cfg_acc && we_q;
  assign mmode = en_q[`EDCR_MASK_MODE_BIT];

  // ****************************************
  // Access sequencer
  // ****************************************
  // Take, serve, answer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q <= d_idle;
    end else begin
      case (st_q)
        d_idle: begin
          if (take) begin
            st_q <= d_acc;
          end
        end
        d_acc: st_q <= d_done;
        d_done: st_q <= d_idle;
        default: st_q <= d_idle;
      endcase
    end
  end

  // Capture of the request
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rgn_q <= 2'd0;
      we_q <= 1'b0;
      adr_q <= 29'h0;
      wd_q <= 16'h0000;
    end else if (take) begin
      rgn_q <= hit_s ? 2'd0 : (hit_a ? 2'd1 : 2'd2);
      we_q <= bus.we;
      adr_q <= bus.addr;
      wd_q <= bus.wdata;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // First window base
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      base_a_q <= `EDCR_RST_REG;
    end else if (cfg_wr && offe == `EDCR_OFF_BASE_A) begin
      base_a_q <= wd_q & WM_BASE_A & `EDCR_BASE_BITS;
    end
  end

  // Second window base
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      base_b_q <= `EDCR_RST_REG;
    end else if (cfg_wr && offe == `EDCR_OFF_BASE_B) begin
      base_b_q <= wd_q & WM_BASE_B & `EDCR_BASE_BITS;
    end
  end

  // DMA request line select
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dma_q <= `EDCR_RST_REG;
    end else if (cfg_wr && offe == `EDCR_OFF_DMA) begin
      dma_q <= wd_q & WM_DMA & `EDCR_DMA_BITS;
    end
  end

  // Device enable and mask mode
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      en_q <= `EDCR_RST_REG;
    end else if (cfg_wr && offe == `EDCR_OFF_EN) begin
      en_q <= wd_q & `EDCR_EN_BITS;
    end
  end

  // Interrupt mask halves
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      msk_q <= 32'h0000_0000;
    end else if (cfg_wr && offe == `EDCR_OFF_MSK_LO) begin
      msk_q[15:0] <= wd_q & WM_IRQ[15:0];
    end else if (cfg_wr && offe == `EDCR_OFF_MSK_HI) begin
      msk_q[31:16] <= wd_q & WM_IRQ[31:16];
    end
  end

  // Write-one-clear pattern for status
  always_comb begin
    clr = 32'h0000_0000;
    if (cfg_wr && offe == `EDCR_OFF_STS_LO) begin
      clr = {16'h0000, wd_q};
    end else if (cfg_wr && offe == `EDCR_OFF_STS_HI) begin
      clr = {wd_q, 16'h0000};
    end
  end

  // Sticky status; a new event beats its clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sts_q <= 32'h0000_0000;
    end else begin
      sts_q <= ((sts_q & ~clr) | irq_src) & WM_IRQ;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Register read mux, mask mode shows settable bits
  always_comb begin
    rd_cfg = 16'h0000;
    if (offe == `EDCR_OFF_ID_LO) begin
      rd_cfg = ID_LO;
    end else if (offe == `EDCR_OFF_ID_HI) begin
      rd_cfg = ID_HI;
    end else if (offe == `EDCR_OFF_CAT) begin
      rd_cfg = CATEGORY;
    end else if (offe == `EDCR_OFF_PROD) begin
      rd_cfg = PRODUCT;
    end else if (offe == `EDCR_OFF_COMP) begin
      rd_cfg = COMPAT;
    end else if (offe == `EDCR_OFF_BASE_A) begin
      rd_cfg = mmode ? (WM_BASE_A & `EDCR_BASE_BITS) : base_a_q;
    end else if (offe == `EDCR_OFF_BASE_B) begin
      rd_cfg = mmode ? (WM_BASE_B & `EDCR_BASE_BITS) : base_b_q;
    end else if (offe == `EDCR_OFF_DMA) begin
      rd_cfg = mmode ? (WM_DMA & `EDCR_DMA_BITS) : dma_q;
    end else if (offe == `EDCR_OFF_EN) begin
      rd_cfg = en_q;
    end else if (offe == `EDCR_OFF_MSK_LO) begin
      rd_cfg = mmode ? WM_IRQ[15:0] : msk_q[15:0];
    end else if (offe == `EDCR_OFF_MSK_HI) begin
      rd_cfg = mmode ? WM_IRQ[31:16] : msk_q[31:16];
    end else if (offe == `EDCR_OFF_STS_LO) begin
      rd_cfg = sts_q[15:0];
    end else if (offe == `EDCR_OFF_STS_HI) begin
      rd_cfg = sts_q[31:16];
    end
  end

  // Read data register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_q <= 16'h0000;
    end else if (st_q == d_acc) begin
      rd_q <= cfg_acc ? rd_cfg : dev_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Bus answer
  assign bus.ack = (st_q == d_done);
  assign bus.rdata = rd_q;

  // Shared open-drain interrupt, pulled low only
  assign bus.irq_o = 1'b0;
  assign bus.irq_oe = |(sts_q & msk_q);

  // Active-low DMA requests, released when unselected
  for (genvar i = 0; i < 3; i++) begin : g_rq
    assign bus.rq_o[i] = ~dma_req[i];
    assign bus.rq_oe[i] = dma_q[i + 1];
  end

  // Device-specific access forwarding
  assign dev_en = en_q[`EDCR_EN_BIT];
  assign dev_req = (st_q == d_acc) && !cfg_acc;
  assign dev_we = we_q;
  assign dev_region = rgn_q;
  assign dev_addr = adr_q;
  assign dev_wdata = wd_q;

endmodule

// >>> core/edcr_host.sv
// Chosen here: register access over APB.
`include "edcr_consts.svh"

module edcr_host
  import edcr_pkg::*;
#(
  // Expected identifier words, values arbitrary
  parameter logic [15:0] ID_LO = 16'h5a01,
  parameter logic [15:0] ID_HI = 16'h5a02
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Expansion bus
  edcr_if.host bus
);

  // ****************************************
  // Declarations
  // ****************************************
  edcr_hst_e st_q;
  edcr_cmd_e cmd_q;
  logic [2:0] step_q;
  logic [3:0] slot_q;
  logic cwe_q;
  logic cext_q;
  logic [28:0] caddr_q;
  logic [15:0] cwd_q;
  logic tout_q;
  logic bridge_q;
  logic [15:0] present_q;
  logic [15:0] res_q [8];
  logic [7:0] reqmap_q;
  logic [`EDCR_TOUT_W-1:0] cnt_q;
  logic req_q;
  logic we_q;
  logic ext_q;
  logic [28:0] addr_q;
  logic [15:0] wd_q;
  logic [31:0] prdata_q;
  edcr_step_s cur;
  logic fin;
  logic fail;
  logic slot_end;
  logic start;
  logic apb_wr;
  logic mapped;

  // Bus steps of each command
  function automatic edcr_step_s step_of(edcr_cmd_e c, logic [2:0] s);
    edcr_step_s r;
    r = '{last: 1'b1, we: 1'b0, off: 10'h000, wd: 16'h0000};
    case (c)
      cmd_enable: begin
        r.we = 1'b1;
        r.off = `EDCR_OFF_EN;
        r.wd = `EDCR_EN_DISCOVER;
      end
      cmd_scan: begin
        r.last = (s == 3'd4);
        r.off = (s == 3'd0) ? `EDCR_OFF_ID_LO : (s == 3'd1) ? `EDCR_OFF_ID_HI :
                (s == 3'd2) ? `EDCR_OFF_PROD : (s == 3'd3) ? `EDCR_OFF_COMP :
                `EDCR_OFF_CAT;
      end
      cmd_discover: begin
        r.last = (s == 3'd6);
        r.we = (s == 3'd0) || (s == 3'd6);
        r.wd = (s == 3'd0) ? `EDCR_EN_DISCOVER : `EDCR_EN_NORMAL;
        r.off = (s == 3'd1) ? `EDCR_OFF_BASE_A : (s == 3'd2) ? `EDCR_OFF_BASE_B :
                (s == 3'd3) ? `EDCR_OFF_DMA : (s == 3'd4) ? `EDCR_OFF_MSK_LO :
                (s == 3'd5) ? `EDCR_OFF_MSK_HI : `EDCR_OFF_EN;
      end
      default: r.last = 1'b1;
    endcase
    step_of = r;
  endfunction

  // ****************************************
  // APB registers
  // ****************************************
  assign apb_wr = psel && penable && pwrite;
  assign start = apb_wr && paddr == `EDCR_APB_CTRL && st_q == h_idle;
  assign mapped = paddr == `EDCR_APB_CTRL || paddr == `EDCR_APB_ADDR
                  || paddr == `EDCR_APB_WDATA || paddr == `EDCR_APB_STATUS
                  || paddr == `EDCR_APB_REQMAP || paddr[7:5] == 3'b001;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  // Command operands
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      caddr_q <= 29'h0;
      cwd_q <= 16'h0000;
    end else if (apb_wr && paddr == `EDCR_APB_ADDR) begin
      caddr_q <= pwdata[28:0];
    end else if (apb_wr && paddr == `EDCR_APB_WDATA) begin
      cwd_q <= pwdata[15:0];
    end
  end

  // Read data loaded in the setup cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == `EDCR_APB_STATUS) begin
        prdata_q <= {present_q, 9'h000, ~bus.rq_n, ~bus.irq_n, bridge_q, tout_q,
                     st_q != h_idle};
      end else if (paddr == `EDCR_APB_REQMAP) begin
        prdata_q <= {24'h000000, reqmap_q};
      end else if (paddr[7:5] == 3'b001) begin
        prdata_q <= {16'h0000, res_q[paddr[4:2]]};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Bus sequencer
  // ****************************************
  assign cur = step_of(cmd_q, step_q);
  assign fail = cnt_q == `EDCR_TOUT_W'(`EDCR_TOUT_CYC - 1);
  assign fin = st_q == h_issue && (bus.ack || fail);
  assign slot_end = fail || step_q == 3'd4
                    || (step_q == 3'd1 && {bus.rdata, res_q[0]} != {ID_HI, ID_LO});

  // Command flow and slot walk
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q <= h_idle;
      cmd_q <= cmd_none;
      step_q <= 3'd0;
      slot_q <= 4'h0;
      cwe_q <= 1'b0;
      cext_q <= 1'b0;
    end else if (start) begin
      st_q <= h_load;
      cmd_q <= edcr_cmd_e'(pwdata[2:0]);
      step_q <= 3'd0;
      slot_q <= (pwdata[2:0] == cmd_scan) ? 4'h0 : pwdata[7:4];
      cwe_q <= pwdata[8];
      cext_q <= pwdata[9];
    end else if (st_q == h_load) begin
      st_q <= h_issue;
    end else if (fin && cmd_q == cmd_scan) begin
      if (!slot_end) begin
        st_q <= h_load;
        step_q <= (step_q == 3'd2 && bus.rdata == 16'h0000) ? 3'd4 : step_q + 3'd1;
      end else if (slot_q == `EDCR_LAST_SLOT || (slot_q == 4'h0 && (fail
                   || step_q != 3'd4 || !bus.rdata[`EDCR_CAT_BRIDGE_BIT]))) begin
        st_q <= h_idle;
      end else begin
        st_q <= h_load;
        step_q <= 3'd0;
        slot_q <= slot_q + 4'h1;
      end
    end else if (fin) begin
      st_q <= (fail || cur.last) ? h_idle : h_load;
      step_q <= step_q + 3'd1;
    end
  end

  // Results, presence, requests and bridge flag
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tout_q <= 1'b0;
      bridge_q <= 1'b0;
      present_q <= 16'h0000;
      reqmap_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        res_q[i] <= 16'h0000;
      end
    end else if (start) begin
      tout_q <= 1'b0;
      if (pwdata[2:0] == cmd_scan) begin
        present_q <= 16'h0000;
        bridge_q <= 1'b0;
      end
      if (pwdata[2:0] == cmd_discover) begin
        reqmap_q <= 8'h00;
      end
    end else if (fin && fail) begin
      tout_q <= 1'b1;
    end else if (fin && !cur.we) begin
      res_q[step_q] <= bus.rdata;
      reqmap_q[step_q] <= cmd_q == cmd_discover && bus.rdata != 16'h0000;
      if (cmd_q == cmd_scan && step_q == 3'd4) begin
        present_q[slot_q] <= 1'b1;
        if (slot_q == 4'h0) begin
          bridge_q <= bus.rdata[`EDCR_CAT_BRIDGE_BIT];
        end
      end
    end
  end

  // Timeout counter while waiting for an answer
  always_ff @(posedge mclk) begin
    if (!rst_b || st_q != h_issue) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `EDCR_TOUT_W'(1);
    end
  end

  // Bus request registers, held until answer or timeout
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      ext_q <= 1'b0;
      addr_q <= 29'h0;
      wd_q <= 16'h0000;
    end else if (st_q == h_load) begin
      req_q <= 1'b1;
      we_q <= (cmd_q == cmd_access) ? cwe_q : cur.we;
      ext_q <= (cmd_q == cmd_access) && cext_q;
      addr_q <= (cmd_q == cmd_access) ? caddr_q : {15'h0000, slot_q, cur.off};
      wd_q <= (cmd_q == cmd_access) ? cwd_q : cur.wd;
    end else if (fin) begin
      req_q <= 1'b0;
    end
  end

  assign bus.req = req_q;
  assign bus.we = we_q;
  assign bus.ext = ext_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wd_q;

endmodule

// >>> verif/edcr_chk.sv
module edcr_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Request side
  input wire logic req,
  input wire logic we,
  input wire logic ext,
  input wire logic [28:0] addr,
  input wire logic [15:0] wdata,
  // Answer side
  input wire logic ack,
  input wire logic [15:0] rdata,
  // Open-drain lines
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire logic [2:0] rq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ************************************
  // Sequences
  // ************************************
  // Slot access taken and answered
  sequence s_acc;
    req ##1 req ##1 ack;
  endsequence
  // Request line select write answered
  sequence s_sel_wr;
    req && we && !ext && addr[9:0] == 10'h014 && ack;
  endsequence

  // ************************************
  // Properties
  // ************************************
  AST_ACK_LAT: assert property (ack |-> $past(req, 2) && $past(req))
    else $error("ack without two cycles of request");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_REQ_DROP: assert property (s_acc |=> !req)
    else $error("request kept after ack");
  AST_REQ_HOLD: assert property (req && !ack |=> !req || $stable(addr))
    else $error("address moved while pending");
  AST_REQ_BOUND: assert property ($rose(req) |-> ##[1:210] !req)
    else $error("request never ends");
  AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  AST_IRQ_LOW: assert property (irq_oe |-> !irq_o)
    else $error("interrupt driven high");
  AST_SEL_LINES: assert property (s_sel_wr |=> rq_oe == $past(wdata[3:1]))
    else $error("request lines differ from select");
  AST_RST_VAL: assert property ($rose(rst_b) |-> !ack && !irq_oe && rq_oe == 3'b000)
    else $error("outputs active after reset");
endmodule

// >>> verif/expansion_device_config_regs_test.sv
module expansion_device_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import edcr_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] slot = 4'h0;
  logic [31:0] irq_src = 32'h0;
  logic [2:0] dma_req = 3'h7;
  logic [15:0] dev_rdata = 16'h1234;
  logic dev_en;
  logic dev_req;
  logic dev_we;
  logic [1:0] dev_region;
  logic [28:0] dev_addr;
  logic [15:0] dev_wdata;
  logic [34:0] seen;
  logic [31:0] rd;
  logic err;
  logic tout;
  int failures = 0;
  int checks = 0;

  // ************************************
  // Clock, ends and checker
  // ************************************
  always #2.5 mclk = ~mclk;
  edcr_if ifc ();
  edcr_host u_edcr_host (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(ifc.host));
  edcr_dev u_edcr_dev (.mclk(mclk), .rst_b(rst_b), .bus(ifc.dev), .slot(slot),
    .irq_src(irq_src), .dma_req(dma_req), .dev_en(dev_en), .dev_req(dev_req),
    .dev_we(dev_we), .dev_region(dev_region), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_rdata(dev_rdata));
  edcr_chk u_edcr_chk (.mclk(mclk), .rst_b(rst_b), .req(ifc.req), .we(ifc.we),
    .ext(ifc.ext), .addr(ifc.addr), .wdata(ifc.wdata), .ack(ifc.ack), .rdata(ifc.rdata),
    .irq_o(ifc.irq_o), .irq_oe(ifc.irq_oe), .rq_oe(ifc.rq_oe));

  // Last forwarded device access
  always @(posedge mclk) begin
    if (dev_req) begin
      seen <= {dev_we, dev_region, dev_addr[15:0], dev_wdata};
    end
  end

  // ************************************
  // Shared tasks
  // ************************************
  // Compare and count
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      failures++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Host command, polled until idle
  task automatic cmd(input logic [31:0] ctrl);
    int n;
    apb(1'b1, 8'h00, ctrl);
    n = 0;
    do begin
      apb(1'b0, 8'h0c, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    if (n == 300) begin
      failures++;
      results();
    end
    tout = rd[1];
  endtask
  // Bus access; read result left in rd
  task automatic acc(input logic w, input logic x, input logic [28:0] a, input logic [15:0] d);
    apb(1'b1, 8'h04, {3'h0, a});
    apb(1'b1, 8'h08, {16'h0, d});
    cmd({22'h0, x, w, slot, 4'h1});
    apb(1'b0, 8'h20, 32'h0);
  endtask
  // Slot register write and read
  task automatic wr(input logic [9:0] off, input logic [15:0] d);
    acc(1'b1, 1'b0, {15'h0, slot, off}, d);
  endtask
  task automatic rchk(input logic [9:0] off, input logic [15:0] e);
    acc(1'b0, 1'b0, {15'h0, slot, off}, 16'h0);
    cmp(rd[15:0], e);
  endtask

  // ************************************
  // Scenarios
  // ************************************
  // Cleared registers after reset
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rchk(10'h010 + 10'(2 * i), 16'h0000);
    end
  endtask
  // Mask mode discovery of settable bits
  task automatic t_discover();
    logic [15:0] e [5] = '{16'h1ff0, 16'h1fff, 16'h000e, 16'hffff, 16'hffff};
    cmd({24'h0, slot, 4'h3});
    for (int i = 1; i <= 5; i++) begin
      apb(1'b0, 8'h20 + 8'(4 * i), 32'h0);
      cmp(rd[15:0], e[i - 1]);
    end
    rchk(10'h016, 16'h0000);
    apb(1'b0, 8'h14, 32'h0);
    cmp(rd[15:0], 16'h003e);
    cmd({24'h0, slot, 4'h4});
    rchk(10'h016, 16'h0002);
    wr(10'h016, 16'h0000);
  endtask
  // Unused bits and request lines
  task automatic t_fields();
    wr(10'h010, 16'hffff);
    rchk(10'h010, 16'h1ff0);
    wr(10'h014, 16'hffff);
    rchk(10'h014, 16'h000e);
    wr(10'h014, 16'h000a);
    cmp({13'h0, ifc.rq_n}, 16'h0002);
    wr(10'h014, 16'h0000);
    cmp({13'h0, ifc.rq_n}, 16'h0007);
    apb(1'b0, 8'h10, 32'h0);
    cmp({15'h0, err}, 16'h0001);
    cmp(rd[15:0], 16'h0000);
  endtask
  // Extended windows and enable
  task automatic t_window();
    wr(10'h010, 16'h0010);
    wr(10'h012, 16'h0020);
    acc(1'b0, 1'b1, {13'h010, 16'h0}, 16'h0);
    cmp({15'h0, tout}, 16'h0001);
    wr(10'h016, 16'h0001);
    cmp({15'h0, dev_en}, 16'h0001);
    acc(1'b1, 1'b1, {13'h010, 16'h0046}, 16'h00a5);
    cmp({13'h0, seen[34:32]}, 16'h0005);
    cmp(seen[31:16], 16'h0046);
    cmp(seen[15:0], 16'h00a5);
    acc(1'b0, 1'b1, {13'h010, 16'h0}, 16'h0);
    cmp({15'h0, tout}, 16'h0000);
    cmp(rd[15:0], 16'h1234);
    cmp({13'h0, seen[34:32]}, 16'h0001);
    acc(1'b0, 1'b1, {13'h020, 16'h0}, 16'h0);
    cmp({15'h0, tout}, 16'h0000);
    cmp({13'h0, seen[34:32]}, 16'h0002);
    wr(10'h012, 16'h0000);
    acc(1'b0, 1'b1, {13'h000, 16'h0}, 16'h0);
    cmp({15'h0, tout}, 16'h0001);
    rchk(10'h016, 16'h0001);
    rchk(10'h040, 16'h1234);
    cmp({13'h0, seen[34:32]}, 16'h0000);
    wr(10'h016, 16'h0000);
  endtask
  // Status, mask and interrupt line
  task automatic t_irq();
    wr(10'h01a, 16'h0001);
    @(posedge mclk);
    irq_src <= 32'h0001_0001;
    @(posedge mclk);
    irq_src <= 32'h0;
    rchk(10'h01e, 16'h0001);
    cmp({15'h0, ifc.irq_n}, 16'h0000);
    rchk(10'h01c, 16'h0001);
    wr(10'h01e, 16'h0001);
    rchk(10'h01e, 16'h0000);
    cmp({15'h0, ifc.irq_n}, 16'h0001);
    wr(10'h01c, 16'h0001);
    rchk(10'h01c, 16'h0000);
  endtask
  // Slot probing, present and absent
  task automatic t_scan();
    cmd({28'h0, 4'h2});
    cmp(rd[31:16], 16'h0001);
    cmp({15'h0, rd[2]}, 16'h0000);
    apb(1'b0, 8'h28, 32'h0);
    cmp(rd[15:0], 16'h0000);
    slot <= 4'h2;
    repeat (3) @(posedge mclk);
    cmd({28'h0, 4'h2});
    cmp(rd[31:16], 16'h0000);
    cmp({15'h0, tout}, 16'h0001);
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_discover();
    t_fields();
    t_window();
    t_irq();
    t_scan();
    results();
  end
endmodule
